// file: rtl/lcdc_core.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// (R1) A data read returns the previously captured byte and captures the next.
// (R2) Host does one dummy read after address set or write.
// (R3) First read after address set does not show that address's data.
// (R4) Written bytes wait in the bus holder, committed before next write.
// (R5) While busy only status reads are taken; host may rely on timing.
// (R6) Status read puts busy on the top data line.
// (R7) Start-line command loads five-bit start register for the first common.
// (R8) Line counter reloads from start register whenever frame polarity changes.
// (R9) Line counter steps on oscillator or slave line clock; 80 bits per line.
// (R10) Seven-bit column counter loads and increments after each data access.
// (R11) Column beyond last column stops incrementing until set again.
// (R12) Column updates never touch the page register.
// (R13) Segment direction command reverses column to segment mapping.
// (R14) Four-bit page register changes only on the set-page command.
// (R15) Page four is the indicator area, only bit zero meaningful.
// (R16) Host RAM access and refresh reads proceed independently.
// (R17) Duty 1/8 or 1/16, plus one adds indicator common.
// (R18) Line latch holds one common period; on/off and static leave data intact.
// (R19) Frame polarity toggles for two-frame alternating drive.
// (R20) Clock stop halts the display clock.
// (R21) Power command writes booster, regulator, follower enables, top to low.
// (R22) Host never enables follower without regulator.
// (R23) Select high means data transfer; low means command write or status read.
// (R24) Line counter wraps after duty's line count, restarting from start line.
module lcdc_core
   import lcdc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire logic i_chip_sel1_n,
   input wire logic i_chip_sel2,
   input wire logic i_register_data_select,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [7:0] i_data,
   output logic [7:0] o_data,
   output logic o_data_oe_n,
   input wire logic i_slave_mode,
   input wire logic i_line_clock_in,
   output logic o_display_clock,
   output logic o_frame_ac_polarity,
   output logic [SEG_W-1:0] o_segment_outputs,
   output logic [COM_W-1:0] o_common_outputs,
   output logic o_indicator_common,
   output logic [2:0] o_power_circuit_enables
);
   lcdc_disp_if disp ();

   logic rd_prev_q;
   logic wr_prev_q;
   logic [7:0] holder_q;
   logic [7:0] data_q;
   logic oe_n_q;
   logic [3:0] busy_cnt_q;
   logic commit_q;
   logic [3:0] wr_page_q;
   logic [6:0] wr_col_q;
   logic [6:0] col_q;
   logic [3:0] page_q;
   logic [4:0] start_q;
   logic [2:0] power_q;
   logic adc_q;
   logic disp_on_q;
   logic static_q;
   logic duty16_q;
   logic duty1_q;
   logic clk_stop_q;
   logic [SEG_W-1:0] latch_q;
   logic [SEG_W-1:0] seg_q;
   logic [COM_W-1:0] com_q;
   logic ind_q;
   logic frame_out_q;
   logic dclk_q;
   logic [7:0] ram_rd_data;
   logic [SEG_W-1:0] latch_map;

   logic sel;
   logic busy;
   logic wr_go;
   logic rd_go;
   logic cmd_acc;
   logic dwr_acc;
   logic drd_acc;
   logic srd_acc;
   lcdc_cmd_e cmd;

   assign sel = !i_chip_sel1_n && i_chip_sel2;
   assign busy = busy_cnt_q != 4'h0;
   assign wr_go = sel && !i_wr_n && wr_prev_q;
   assign rd_go = sel && !i_rd_n && rd_prev_q;
   // Select pin splits data from command/status [R23]; busy refuses all but status [R5]
   assign cmd_acc = wr_go && !busy && !i_register_data_select;
   assign dwr_acc = wr_go && !busy && i_register_data_select;
   assign drd_acc = rd_go && !busy && i_register_data_select;
   assign srd_acc = rd_go && !i_register_data_select;
   assign cmd = cmd_acc ? lcdc_decode(i_data) : CK_NONE;

   assign disp.start_line = start_q;
   assign disp.duty16 = duty16_q;
   assign disp.duty_plus1 = duty1_q;
   assign disp.slave = i_slave_mode;
   assign disp.clk_stop = clk_stop_q;
   assign disp.line_clk = i_line_clock_in;

   lcdc_scan u_scan (
      .i_sys_clk(i_sys_clk),
      .i_reset(i_reset),
      .disp(disp.scan)
   );

   lcdc_ram u_ram (
      .i_sys_clk(i_sys_clk),
      .i_we(commit_q),
      .i_wr_page(wr_page_q),
      .i_wr_col(wr_col_q),
      .i_wr_data(holder_q),
      .i_rd_page(page_q),
      .i_rd_col(col_q),
      .o_rd_data(ram_rd_data),
      .disp(disp.ram)
   );

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         rd_prev_q <= 1'b1;
         wr_prev_q <= 1'b1;
      end else begin
         rd_prev_q <= i_rd_n || !sel;
         wr_prev_q <= i_wr_n || !sel;
      end
   end

   // Shared bus holder: read pipeline and write staging [R1] [R3] [R4]
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         holder_q <= 8'h00;
      end else if (dwr_acc) begin
         holder_q <= i_data;
      end else if (drd_acc) begin
         holder_q <= ram_rd_data;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         data_q <= 8'h00;
      end else if (srd_acc) begin
         data_q <= 8'h00;
         data_q[ST_BUSY] <= busy; // [R6]
         data_q[ST_ADC] <= adc_q;
         data_q[ST_OFF] <= !disp_on_q;
      end else if (drd_acc) begin
         data_q <= holder_q; // [R1]
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         oe_n_q <= 1'b1;
      end else begin
         oe_n_q <= !(sel && !i_rd_n);
      end
   end

   // Commit lands in the first busy cycle, so always before the next write [R4]
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         busy_cnt_q <= 4'h0;
         commit_q <= 1'b0;
         wr_page_q <= RST_PAGE;
         wr_col_q <= RST_COL;
      end else begin
         commit_q <= dwr_acc;
         if (cmd_acc || dwr_acc) begin
            busy_cnt_q <= BUSY_CYC;
         end else if (busy) begin
            busy_cnt_q <= busy_cnt_q - 4'h1;
         end
         if (dwr_acc) begin
            wr_page_q <= page_q;
            wr_col_q <= col_q;
         end
      end
   end

   // Column counter only; page is left alone [R12]
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         col_q <= RST_COL;
      end else if (cmd == CK_COL_LO) begin
         col_q[3:0] <= i_data[3:0]; // [R10]
      end else if (cmd == CK_COL_HI) begin
         col_q[6:4] <= i_data[2:0]; // [R10]
      end else if ((dwr_acc || drd_acc) && col_q < COL_COUNT) begin
         col_q <= col_q + 7'h01; // [R10] [R11]
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         page_q <= RST_PAGE;
      end else if (cmd == CK_PAGE) begin
         page_q <= i_data[3:0]; // [R14]
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         start_q <= RST_START;
         power_q <= RST_POWER;
         adc_q <= 1'b0;
         disp_on_q <= 1'b0;
         static_q <= 1'b0;
         duty16_q <= 1'b1;
         duty1_q <= 1'b0;
         clk_stop_q <= 1'b0;
      end else begin
         unique case (cmd)
            CK_START: start_q <= i_data[4:0]; // [R7]
            CK_POWER: power_q <= i_data[2:0]; // [R21]
            CK_ADC: adc_q <= i_data[0]; // [R13]
            CK_DISP: disp_on_q <= i_data[0]; // [R18]
            CK_STATIC: static_q <= i_data[0]; // [R18]
            CK_DUTY: duty16_q <= i_data[0]; // [R17]
            CK_DUTY1: duty1_q <= i_data[0]; // [R17]
            CK_CLK: clk_stop_q <= i_data[0]; // [R20]
            CK_NONE, CK_COL_LO, CK_COL_HI, CK_PAGE: ;
         endcase
      end
   end

   // Segment direction is a pure output remap; stored data keeps its order [R13]
   for (genvar s = 0; s < SEG_W; s++) begin : g_map
      assign latch_map[s] = adc_q ? latch_q[SEG_W-1-s] : latch_q[s];
   end

   // One common period of data, captured as the scan leaves each line [R18]
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         latch_q <= '0;
         com_q <= '0;
         ind_q <= 1'b0;
      end else if (disp.step) begin
         latch_q <= disp.row_bits;
         com_q <= '0;
         ind_q <= disp.ind_line; // [R17]
         if (!disp.ind_line && disp.com_idx < 5'(COM_W)) begin
            com_q[disp.com_idx[3:0]] <= 1'b1;
         end
      end
   end

   // On/off and static gate the outputs only, never the latch [R18]
   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         seg_q <= '0;
         frame_out_q <= 1'b1;
         dclk_q <= 1'b0;
      end else begin
         seg_q <= static_q ? '1 : (disp_on_q ? latch_map : '0);
         frame_out_q <= disp.frame_ac; // [R19]
         if (disp.step && !i_slave_mode) begin
            dclk_q <= !dclk_q; // [R20]
         end
      end
   end

   assign o_data = data_q;
   assign o_data_oe_n = oe_n_q;
   assign o_display_clock = dclk_q;
   assign o_frame_ac_polarity = frame_out_q;
   assign o_segment_outputs = seg_q;
   assign o_common_outputs = com_q;
   assign o_indicator_common = ind_q;
   assign o_power_circuit_enables = power_q;

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   sequence s_data_write;
      dwr_acc;
   endsequence
   sequence s_commit(logic [7:0] b);
      commit_q && holder_q == b;
   endsequence

   AST_READ_PIPE: assert property (drd_acc |=> data_q == $past(holder_q)) // [R1]
      else $error("data read did not return held byte");
   AST_FIRST_READ: assert property (drd_acc |=> holder_q == $past(ram_rd_data)) // [R3]
      else $error("read did not capture addressed byte");
   AST_COMMIT: assert property (s_data_write |=> s_commit($past(i_data)) ##1 !commit_q) // [R4]
      else $error("write not committed in next cycle");
   AST_BUSY_REFUSE: assert property (busy && (wr_go || rd_go) && i_register_data_select // [R5]
                                     |=> $stable(holder_q) && $stable(col_q))
      else $error("access taken while busy");
   AST_STATUS: assert property (srd_acc |=> data_q[ST_BUSY] == $past(busy)) // [R6]
      else $error("status busy bit wrong");
   AST_START_LOAD: assert property (cmd == CK_START |=> start_q == $past(i_data[4:0])) // [R7]
      else $error("start line not loaded");
   AST_COL_STEP: assert property ((dwr_acc || drd_acc) && col_q < COL_COUNT // [R10]
                                  |=> col_q == $past(col_q) + 7'h01)
      else $error("column did not increment");
   AST_COL_LOCK: assert property (col_q >= COL_COUNT && cmd != CK_COL_LO && cmd != CK_COL_HI // [R11]
                                  |=> $stable(col_q))
      else $error("locked column moved");
   AST_PAGE_HOLD: assert property (cmd != CK_PAGE |=> $stable(page_q)) // [R12] [R14]
      else $error("page changed without command");
   AST_POWER: assert property (cmd == CK_POWER |=> o_power_circuit_enables == $past(i_data[2:0])) // [R21]
      else $error("power enables not written");
   AST_LATCH_KEEP: assert property (!disp.step |=> $stable(latch_q)) // [R18]
      else $error("latch changed between lines");
endmodule
`default_nettype wire

// file: rtl/lcdc_disp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lcdc_disp_if;
   logic [4:0] start_line;
   logic duty16;
   logic duty_plus1;
   logic slave;
   logic clk_stop;
   logic line_clk;
   logic step;
   logic frame_ac;
   logic ind_line;
   logic [4:0] com_idx;
   logic [4:0] line_addr;
   logic [79:0] row_bits;
   modport ctrl (output start_line, duty16, duty_plus1, slave, clk_stop, line_clk,
                 input step, frame_ac, ind_line, com_idx, row_bits);
   modport scan (input start_line, duty16, duty_plus1, slave, clk_stop, line_clk,
                 output step, frame_ac, ind_line, com_idx, line_addr);
   modport ram (input line_addr, ind_line, output row_bits);
endinterface
`default_nettype wire

// file: rtl/lcdc_pkg.sv
package lcdc_pkg;
   localparam int SEG_W = 80;
   localparam int COM_W = 16;
   localparam int PAGES = 5;
   localparam int RAM_DEPTH = SEG_W * PAGES;
   localparam logic [6:0] COL_COUNT = 7'h50;
   localparam logic [3:0] PAGE_IND = 4'h4;
   localparam logic [4:0] LINES_LO = 5'h08;
   localparam logic [4:0] LINES_HI = 5'h10;
   localparam int SYS_CLK_NS = 100;
   localparam int LINE_TIME_NS = 2000;
   localparam int LINE_CYC = (LINE_TIME_NS / SYS_CLK_NS < 1) ? 1 : LINE_TIME_NS / SYS_CLK_NS;
   localparam int BUSY_TIME_NS = 200;
   localparam int BUSY_CYC_I = (BUSY_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam logic [3:0] BUSY_CYC = 4'(BUSY_CYC_I < 1 ? 1 : BUSY_CYC_I);
   localparam int ST_BUSY = 7;
   localparam int ST_ADC = 6;
   localparam int ST_OFF = 5;
   localparam logic [4:0] RST_START = 5'h00;
   localparam logic [6:0] RST_COL = 7'h00;
   localparam logic [3:0] RST_PAGE = 4'h0;
   localparam logic [2:0] RST_POWER = 3'h0;
   localparam logic [7:0] IND_MASK = 8'h01;
   localparam logic [7:0] CMD_COL_LO = 8'h00;
   localparam logic [7:0] CMD_COL_HI = 8'h10;
   localparam logic [7:0] CMD_POWER = 8'h28;
   localparam logic [7:0] CMD_START = 8'h40;
   localparam logic [7:0] CMD_ADC = 8'ha0;
   localparam logic [7:0] CMD_STATIC = 8'ha4;
   localparam logic [7:0] CMD_DUTY = 8'ha8;
   localparam logic [7:0] CMD_DUTY1 = 8'haa;
   localparam logic [7:0] CMD_DISP = 8'hae;
   localparam logic [7:0] CMD_PAGE = 8'hb0;
   localparam logic [7:0] CMD_CLK = 8'hc0;

   typedef enum logic [3:0] {
      CK_NONE, CK_COL_LO, CK_COL_HI, CK_POWER, CK_START, CK_ADC,
      CK_STATIC, CK_DUTY, CK_DUTY1, CK_DISP, CK_PAGE, CK_CLK
   } lcdc_cmd_e;

   function automatic lcdc_cmd_e lcdc_decode(input logic [7:0] b);
      lcdc_cmd_e k;
      k = CK_NONE;
      if ((b & 8'hf0) == CMD_COL_LO) k = CK_COL_LO;
      else if ((b & 8'hf8) == CMD_COL_HI) k = CK_COL_HI;
      else if ((b & 8'hf8) == CMD_POWER) k = CK_POWER;
      else if ((b & 8'he0) == CMD_START) k = CK_START;
      else if ((b & 8'hfe) == CMD_ADC) k = CK_ADC;
      else if ((b & 8'hfe) == CMD_STATIC) k = CK_STATIC;
      else if ((b & 8'hfe) == CMD_DUTY) k = CK_DUTY;
      else if ((b & 8'hfe) == CMD_DUTY1) k = CK_DUTY1;
      else if ((b & 8'hfe) == CMD_DISP) k = CK_DISP;
      else if ((b & 8'hf0) == CMD_PAGE) k = CK_PAGE;
      else if ((b & 8'hfe) == CMD_CLK) k = CK_CLK;
      return k;
   endfunction

   function automatic logic [8:0] lcdc_ram_index(input logic [3:0] page, input logic [6:0] col);
      return 9'(9'(page) * 9'h050 + 9'(col));
   endfunction
endpackage

// file: rtl/lcdc_ram.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_ram
   import lcdc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_we,
   input wire logic [3:0] i_wr_page,
   input wire logic [6:0] i_wr_col,
   input wire logic [7:0] i_wr_data,
   input wire logic [3:0] i_rd_page,
   input wire logic [6:0] i_rd_col,
   output logic [7:0] o_rd_data,
   lcdc_disp_if.ram disp
);
   logic [7:0] mem [RAM_DEPTH];

   // Host port and refresh port are independent; refresh never waits [R16]
   always_ff @(posedge i_sys_clk) begin
      if (i_we && i_wr_col < COL_COUNT && i_wr_page <= PAGE_IND) begin
         // Indicator page keeps only its low bit [R15]
         mem[lcdc_ram_index(i_wr_page, i_wr_col)] <=
            (i_wr_page == PAGE_IND) ? (i_wr_data & IND_MASK) : i_wr_data;
      end
   end

   always_comb begin
      o_rd_data = 8'h00;
      if (i_rd_col < COL_COUNT && i_rd_page <= PAGE_IND) begin
         o_rd_data = mem[lcdc_ram_index(i_rd_page, i_rd_col)];
      end
   end

   // One full line of 80 bits per line address [R9]
   for (genvar c = 0; c < SEG_W; c++) begin : g_row
      logic [7:0] ind_byte;
      logic [7:0] line_byte;
      assign ind_byte = mem[lcdc_ram_index(PAGE_IND, 7'(c))];
      assign line_byte = mem[lcdc_ram_index({2'b00, disp.line_addr[4:3]}, 7'(c))];
      assign disp.row_bits[c] = disp.ind_line ? ind_byte[0] : line_byte[disp.line_addr[2:0]];
   end
endmodule
`default_nettype wire

// file: rtl/lcdc_scan.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_scan
   import lcdc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   lcdc_disp_if.scan disp
);
   logic [7:0] div_q;
   logic lclk_prev_q;
   logic [4:0] idx_q;
   logic [4:0] line_q;
   logic frame_q;
   logic [4:0] nlines;
   logic last;
   logic tick;

   assign nlines = (disp.duty16 ? LINES_HI : LINES_LO) + {4'h0, disp.duty_plus1};
   assign last = idx_q == nlines - 5'h01;
   assign tick = !disp.clk_stop && div_q == 8'(LINE_CYC - 1);
   // Master steps on the oscillator divider, slave on the line clock edge [R9] [R20]
   assign disp.step = disp.slave ? (disp.line_clk && !lclk_prev_q) : tick;
   assign disp.frame_ac = frame_q;
   assign disp.ind_line = disp.duty_plus1 && last;
   assign disp.com_idx = idx_q;
   assign disp.line_addr = line_q;

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         div_q <= 8'h00;
      end else if (disp.clk_stop || tick) begin
         div_q <= 8'h00;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         lclk_prev_q <= 1'b0;
      end else begin
         lclk_prev_q <= disp.line_clk;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_reset) begin
      if (i_reset) begin
         idx_q <= 5'h00;
         line_q <= RST_START;
         frame_q <= 1'b1;
      end else if (disp.step) begin
         if (last || idx_q >= nlines) begin
            idx_q <= 5'h00;
            frame_q <= !frame_q; // [R19]
            line_q <= disp.start_line; // [R8] [R24]
         end else begin
            idx_q <= idx_q + 5'h01;
            line_q <= line_q + 5'h01;
         end
      end
   end

   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   AST_RELOAD: assert property ($changed(frame_q) |-> line_q == $past(disp.start_line)) // [R8]
      else $error("line counter not reloaded on frame change");
   AST_WRAP: assert property (disp.step && last |=> idx_q == 5'h00 && frame_q != $past(frame_q)) // [R24]
      else $error("scan did not wrap after last line");
   AST_STOPPED: assert property (disp.clk_stop && !disp.slave |-> !disp.step) // [R20]
      else $error("scan stepped with clock stopped");
endmodule
`default_nettype wire

// file: sim/lcdc_core_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_core_tb_top;
   import lcdc_pkg::*;
   logic clk, rst, cs1_n, cs2, rds, rd_n, wr_n, oe_n, dclk, frame, ind, slv, lclk;
   logic [7:0] wdata, rdata;
   logic [79:0] segs;
   logic [15:0] coms;
   logic [2:0] pwr;
   int n_fail = 0;
   int compares = 0;

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   lcdc_host_model lcdc_host_model_i (.i_sys_clk(clk), .i_data(rdata), .i_data_oe_n(oe_n), .o_cs1_n(cs1_n),
      .o_cs2(cs2), .o_reg_data_sel(rds), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_wdata(wdata));

   lcdc_core lcdc_core_i (.i_sys_clk(clk), .i_reset(rst), .i_chip_sel1_n(cs1_n), .i_chip_sel2(cs2),
      .i_register_data_select(rds), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(wdata), .o_data(rdata),
      .o_data_oe_n(oe_n), .i_slave_mode(slv), .i_line_clock_in(lclk), .o_display_clock(dclk),
      .o_frame_ac_polarity(frame), .o_segment_outputs(segs), .o_common_outputs(coms),
      .o_indicator_common(ind), .o_power_circuit_enables(pwr));

   task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("Counts: %0d compares, %0d n_fail", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic set_addr(input logic [3:0] pg, input logic [6:0] col);
      lcdc_host_model_i.wr(1'b0, CMD_PAGE | 8'(pg), 1);
      lcdc_host_model_i.wr(1'b0, CMD_COL_LO | 8'(col[3:0]), 1);
      lcdc_host_model_i.wr(1'b0, CMD_COL_HI | 8'(col[6:4]), 1);
   endtask

   task automatic rd_chk(input logic a0v, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      logic o;
      lcdc_host_model_i.rd(a0v, d, o);
      chk(80'(d), 80'(exp), msg);
      chk(80'(o), 80'h0, "read enable");
   endtask

   task automatic t_pipe;
      logic [7:0] d;
      logic o;
      set_addr(4'h1, 7'h05);
      lcdc_host_model_i.wr(1'b1, 8'haa, 1);
      lcdc_host_model_i.wr(1'b1, 8'h55, 1);
      set_addr(4'h2, 7'h05);
      lcdc_host_model_i.wr(1'b1, 8'h77, 1);
      set_addr(4'h1, 7'h05);
      lcdc_host_model_i.rd(1'b1, d, o);
      rd_chk(1'b1, 8'haa, "second read");
      rd_chk(1'b1, 8'h55, "next column");
      set_addr(4'h2, 7'h04);
      lcdc_host_model_i.wr(1'b1, 8'h33, 0);
      lcdc_host_model_i.wr(1'b1, 8'h44, 1);
      set_addr(4'h2, 7'h04);
      lcdc_host_model_i.rd(1'b1, d, o);
      rd_chk(1'b1, 8'h33, "write before busy");
      rd_chk(1'b1, 8'h77, "write refused while busy");
      set_addr(4'h1, 7'h4f);
      lcdc_host_model_i.wr(1'b1, 8'h11, 1);
      lcdc_host_model_i.wr(1'b1, 8'h22, 1);
      set_addr(4'h1, 7'h4f);
      lcdc_host_model_i.rd(1'b1, d, o);
      rd_chk(1'b1, 8'h11, "last column");
      rd_chk(1'b1, 8'h00, "beyond last");
      rd_chk(1'b1, 8'h00, "frozen column");
      set_addr(4'h3, 7'h00);
      lcdc_host_model_i.wr(1'b1, 8'h00, 1);
      // Unlocked, column 7f would wrap to 0 and the second byte would land there
      set_addr(4'h3, 7'h7f);
      lcdc_host_model_i.wr(1'b1, 8'h5a, 1);
      lcdc_host_model_i.wr(1'b1, 8'ha5, 1);
      set_addr(4'h3, 7'h00);
      lcdc_host_model_i.rd(1'b1, d, o);
      rd_chk(1'b1, 8'h00, "locked column");
      set_addr(PAGE_IND, 7'h00);
      lcdc_host_model_i.wr(1'b1, 8'hff, 1);
      set_addr(PAGE_IND, 7'h00);
      lcdc_host_model_i.rd(1'b1, d, o);
      rd_chk(1'b1, IND_MASK, "indicator page");
      $display("Test pipeline done");
   endtask

   task automatic t_power;
      logic [2:0] p[4] = '{3'h7, 3'h4, 3'h3, 3'h0};
      for (int i = 0; i < 4; i++) begin
         lcdc_host_model_i.wr(1'b0, CMD_POWER | 8'(p[i]), 1);
         chk(80'(pwr), 80'(p[i]), "power enables");
      end
      lcdc_host_model_i.wr(1'b0, CMD_POWER | 8'h07, 0);
      rd_chk(1'b0, 8'ha0, "busy status");
      rd_chk(1'b0, 8'h20, "idle status");
      $display("Test power and status done");
   endtask

   task automatic wait_frame(output int n, output int hi);
      logic f;
      n = 0;
      hi = 0;
      for (int j = 0; j < 3; j++) begin
         f = frame;
         n = 0;
         hi = 0;
         while (frame === f && n < 2000) begin
            @(negedge clk);
            n++;
            if (ind === 1'b1) hi++;
         end
      end
   endtask

   task automatic t_duty;
      logic [7:0] dc[4] = '{8'ha8, 8'ha8, 8'ha9, 8'ha9};
      int n, hi, lines;
      for (int i = 0; i < 4; i++) begin
         lcdc_host_model_i.wr(1'b0, dc[i], 1);
         lcdc_host_model_i.wr(1'b0, CMD_DUTY1 | 8'(i % 2), 1);
         lines = (i < 2 ? 8 : 16) + i % 2;
         wait_frame(n, hi);
         chk(80'(n), 80'(lines * LINE_CYC), "frame length");
         chk(80'(hi), 80'((i % 2) * LINE_CYC), "indicator common");
      end
      lcdc_host_model_i.wr(1'b0, CMD_CLK | 8'h01, 1);
      n = 0;
      hi = dclk;
      repeat (3 * LINE_CYC) begin
         @(negedge clk);
         if (dclk !== 1'(hi)) n++;
      end
      chk(80'(n), 80'h0, "clock stopped");
      lcdc_host_model_i.wr(1'b0, CMD_CLK, 1);
      n = 0;
      hi = dclk;
      repeat (3 * LINE_CYC) begin
         @(negedge clk);
         if (dclk !== 1'(hi)) begin
            n++;
            hi = dclk;
         end
      end
      chk(80'(n), 80'h3, "clock running");
      $display("Test duty done");
   endtask

   task automatic t_slave;
      logic f, d0;
      int n;
      d0 = dclk;
      slv = 1'b1;
      for (int j = 0; j < 2; j++) begin
         f = frame;
         n = 0;
         while (frame === f && n < 40) begin
            lclk = 1'b1;
            repeat (2) @(negedge clk);
            lclk = 1'b0;
            repeat (2) @(negedge clk);
            n++;
         end
      end
      chk(80'(n), 80'h11, "slave frame length");
      chk(80'(dclk), 80'(d0), "slave display clock");
      slv = 1'b0;
      $display("Test slave done");
   endtask

   task automatic show(input logic [7:0] cmd, input logic [79:0] exp, input string msg);
      int k;
      lcdc_host_model_i.wr(1'b0, cmd, 1);
      repeat (2) begin
         // Fresh line-zero entries only, so a new start line has been reloaded
         k = 0;
         while (coms === 16'h0001 && k < 400) begin
            @(negedge clk);
            k++;
         end
         while (coms !== 16'h0001 && k < 400) begin
            @(negedge clk);
            k++;
         end
         repeat (2) @(negedge clk);
      end
      chk(segs, exp, msg);
   endtask

   task automatic t_display;
      set_addr(4'h0, 7'h00);
      // Whole page written, so no unset cell reaches the segments on common zero
      for (int c = 0; c < SEG_W; c++) begin
         lcdc_host_model_i.wr(1'b1, c == 0 ? 8'h03 : (c == 1 ? 8'h02 : 8'h00), 1);
      end
      lcdc_host_model_i.wr(1'b0, CMD_DUTY, 1);
      lcdc_host_model_i.wr(1'b0, CMD_DUTY1, 1);
      lcdc_host_model_i.wr(1'b0, CMD_DISP | 8'h01, 1);
      show(CMD_START, 80'h1, "start line zero");
      show(CMD_START | 8'h01, 80'h3, "start line one");
      show(CMD_ADC | 8'h01, {2'b11, 78'h0}, "reversed segments");
      rd_chk(1'b0, 8'h40, "reverse status");
      show(CMD_STATIC | 8'h01, {80{1'b1}}, "static drive");
      show(CMD_STATIC, {2'b11, 78'h0}, "static off");
      show(CMD_DISP, 80'h0, "display off");
      show(CMD_DISP | 8'h01, {2'b11, 78'h0}, "display back on");
      $display("Test display done");
   endtask

   initial begin
      rst = 1'b1;
      slv = 1'b0;
      lclk = 1'b0;
      repeat (12) @(negedge clk);
      chk(80'({rdata, oe_n, frame, pwr, coms, ind, dclk}), 80'({8'h00, 2'b11, 19'h0, 2'b00}), "reset outputs");
      chk(segs, 80'h0, "reset segments");
      rst = 1'b0;
      t_pipe();
      t_power();
      t_duty();
      t_slave();
      t_display();
      give_verdict();
   end

   initial begin
      #2ms;
      n_fail++;
      $display("Error at %0t: watchdog expired", $time);
      give_verdict();
   end
endmodule
`default_nettype wire

// file: sim/lcdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcdc_host_model (
   input wire logic i_sys_clk,
   input wire logic [7:0] i_data,
   input wire logic i_data_oe_n,
   output logic o_cs1_n,
   output logic o_cs2,
   output logic o_reg_data_sel,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic [7:0] o_wdata
);
   initial begin
      o_cs1_n = 1'b1;
      o_cs2 = 1'b0;
      o_reg_data_sel = 1'b0;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_wdata = 8'h00;
   end

   // Gap 0 lands the next access inside busy; callers only do that on purpose
   task automatic wr(input logic is_data, input logic [7:0] d, input int gap);
      @(negedge i_sys_clk);
      o_cs1_n = 1'b0;
      o_cs2 = 1'b1;
      o_reg_data_sel = is_data;
      o_wdata = d;
      o_wr_n = 1'b0;
      @(negedge i_sys_clk);
      o_wr_n = 1'b1;
      o_cs1_n = 1'b1;
      o_cs2 = 1'b0;
      o_wdata = ~d;
      repeat (gap) @(negedge i_sys_clk);
   endtask

   task automatic rd(input logic is_data, output logic [7:0] d, output logic oe_n);
      @(negedge i_sys_clk);
      o_cs1_n = 1'b0;
      o_cs2 = 1'b1;
      o_reg_data_sel = is_data;
      o_rd_n = 1'b0;
      repeat (2) @(negedge i_sys_clk);
      d = i_data;
      oe_n = i_data_oe_n;
      o_rd_n = 1'b1;
      o_cs1_n = 1'b1;
      o_cs2 = 1'b0;
   endtask
endmodule
`default_nettype wire
